// ==== rtl/option_byte_consts.vh ====
// Constants for the option byte loader
`ifndef OPTION_BYTE_CONSTS_VH
`define OPTION_BYTE_CONSTS_VH
`define OB_IDX_WDT      10'h0c0
`define OB_IDX_VDT      10'h0c1
`define OB_IDX_OSC      10'h0c2
`define OB_IDX_DBG      10'h0c3
`define OB_IDX_STATUS   10'h0c4
`define OB_IDX_CTRL     10'h0c5
`define OB_FLASH_BASE   17'h000c0
`define OB_FLASH_MIRROR 17'h010c0
`define OB_NUM_BYTES    3'h4
`define OB_WDT_IRQ      7
`define OB_WDT_WIN_HI   6
`define OB_WDT_WIN_LO   5
`define OB_WDT_RUN      4
`define OB_WDT_PER_HI   3
`define OB_WDT_PER_LO   1
`define OB_WDT_STBY     0
`define OB_VDT_VPOC_HI  7
`define OB_VDT_VPOC_LO  5
`define OB_VDT_LVIS_HI  3
`define OB_VDT_LVIS_LO  2
`define OB_VDT_MODE_HI  1
`define OB_VDT_MODE_LO  0
`define OB_VDT_INTRST   2'h2
`define OB_VDT_RSTONLY  2'h3
`define OB_CTRL_RELOAD  0
`define OB_RST_BYTE     8'h00
`define OB_RESP_OKAY    2'h0
`define OB_RESP_SLVERR  2'h2
`define OB_RESP_DECERR  2'h3
`endif

// ==== rtl/wdt_option_decode.v ====
// Watchdog option byte field decoder
`include "option_byte_consts.vh"
module wdt_option_decode (
    input  wire [7:0]  wdt_byte,
    output wire [4:0]  overflow_exponent,
    output wire [16:0] interval_point,
    output wire        window_prohibited
);
    // ****************************************
    // Period code to power of two
    // ****************************************
    function [4:0] period_exp;
        input [2:0] code;
        begin
            case (code)
                3'h0: period_exp = 5'h06;
                3'h1: period_exp = 5'h07;
                3'h2: period_exp = 5'h08;
                3'h3: period_exp = 5'h09;
                3'h4: period_exp = 5'h0b;
                3'h5: period_exp = 5'h0d;
                3'h6: period_exp = 5'h0e;
                default: period_exp = 5'h10;
            endcase
        end
    endfunction

    wire [4:0] shift_amt;

    assign overflow_exponent = period_exp(wdt_byte[`OB_WDT_PER_HI:`OB_WDT_PER_LO]);
    assign shift_amt         = overflow_exponent - 5'h02;
    // Three quarters of the overflow count
    assign interval_point    = 17'h00003 << shift_amt;
    assign window_prohibited = wdt_byte[`OB_WDT_WIN_HI:`OB_WDT_WIN_LO] == 2'h0;
endmodule

// ==== rtl/lvd_option_decode.v ====
// Voltage detector option byte decoder
`include "option_byte_consts.vh"
module vdt_option_decode (
    input  wire [7:0] vdt_byte,
    output wire       detector_off,
    output reg  [3:0] pair_index,
    output reg  [1:0] low_index,
    output reg        vdt_prohibited
);
    // ****************************************
    // Single pair table lookup
    // ****************************************
    function [4:0] single_pair;
        input [4:0] sel;
        begin
            case (sel)
                5'h03: single_pair = 5'h00;
                5'h02: single_pair = 5'h01;
                5'h07: single_pair = 5'h02;
                5'h06: single_pair = 5'h03;
                5'h05: single_pair = 5'h04;
                5'h0b: single_pair = 5'h05;
                5'h0a: single_pair = 5'h06;
                5'h09: single_pair = 5'h07;
                5'h0f: single_pair = 5'h08;
                5'h0e: single_pair = 5'h09;
                5'h0d: single_pair = 5'h0a;
                5'h04: single_pair = 5'h0b;
                5'h08: single_pair = 5'h0c;
                5'h0c: single_pair = 5'h0d;
                default: single_pair = 5'h10;
            endcase
        end
    endfunction

    wire [2:0] vpoc;
    wire [1:0] lvis;
    wire [1:0] mode;
    wire [4:0] single;

    assign vpoc   = vdt_byte[`OB_VDT_VPOC_HI:`OB_VDT_VPOC_LO];
    assign lvis   = vdt_byte[`OB_VDT_LVIS_HI:`OB_VDT_LVIS_LO];
    assign mode   = vdt_byte[`OB_VDT_MODE_HI:`OB_VDT_MODE_LO];
    assign single = single_pair({vpoc, lvis});
    assign detector_off = mode[0] & vpoc[2];

    always @* begin
        pair_index     = single[3:0];
        low_index      = 2'h0;
        vdt_prohibited = 1'b0;
        if (mode == `OB_VDT_INTRST) begin
            // Falling low level by class, high pair by level select
            low_index      = vpoc[1:0];
            pair_index     = {vpoc[1:0], 2'h0} - {2'h0, vpoc[1:0]} + {2'h0, 2'h2 - lvis};
            vdt_prohibited = vpoc[2] | (lvis == 2'h3);
        end else if (mode[0] && !detector_off) begin
            vdt_prohibited = single[4];
        end else if (!mode[0]) begin
            vdt_prohibited = 1'b1;
        end
    end
endmodule

// ==== rtl/option_byte_config_decoder.v ====
// Option byte loader with register view over AXI4-Lite
//
// Overview of operation
// - Option bytes are fetched and applied after every reset release.
// - Software cannot alter any option byte value.
// - Image is three user bytes from 0x000c0 plus debug byte 0x000c3.
// - First byte holds watchdog interrupt, window, enable, period, standby.
// - Standby bit zero halts watchdog counting in halt or stop.
// - Period code picks 2^6 up to 2^16 slow clock cycles.
// - Enable bit starts watchdog after reset release, else stays stopped.
// - Window codes 01,10,11 give 50,75,100 percent; 00 prohibited.
// - Interval interrupt point at 75 percent when select bit set.
// - Mode 10 is interrupt and reset with high pair, low level.
// - Mode 11 is reset only with one tabulated threshold pair.
// - Third byte sets fast oscillator and flash mode in same load.
`include "option_byte_consts.vh"
module option_byte_config_decoder #(
    parameter ADDR_W = 12
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg               flash_rd_req,
    output reg  [16:0]       flash_rd_addr,
    input  wire [7:0]        flash_rd_data,
    input  wire              flash_rd_valid,
    input  wire              boot_swap,
    input  wire              low_power_state,
    output reg               reset_hold_n,
    output reg               watchdog_run_enable,
    output reg               watchdog_count_gate,
    output reg               standby_count_enable,
    output reg  [2:0]        overflow_period_sel,
    output reg  [4:0]        overflow_exponent,
    output reg               interval_irq_select,
    output reg  [16:0]       interval_point,
    output reg               refresh_span_hi,
    output reg               refresh_span_lo,
    output reg  [1:0]        detector_mode,
    output reg  [2:0]        voltage_class,
    output reg  [1:0]        level_select,
    output reg               detector_off,
    output reg  [3:0]        threshold_pair_index,
    output reg  [1:0]        low_threshold_index,
    output reg  [7:0]        fast_osc_flash_byte,
    output reg  [7:0]        debug_option_byte,
    output reg               config_error
);
    // ****************************************
    // Loader states
    // ****************************************
    localparam S_START = 2'h0;
    localparam S_FETCH = 2'h1;
    localparam S_APPLY = 2'h2;
    localparam S_DONE  = 2'h3;

    function [9:0] word_index;
        input [ADDR_W-1:0] addr;
        begin
            word_index = addr[11:2];
        end
    endfunction

    reg  [1:0]  state_q;
    reg  [1:0]  byte_cnt_q;
    reg         swap_q;
    reg  [7:0]  img_q [0:3];
    reg  [7:0]  wdt_q;
    reg  [7:0]  vdt_q;
    reg         loaded_q;
    reg         reload_q;
    reg         aw_have_q;
    reg         w_have_q;
    reg  [9:0]  aw_idx_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg  [31:0] rd_word;
    reg  [1:0]  rd_resp;
    wire [4:0]  exp_w;
    wire [16:0] ipoint_w;
    wire        win_bad_w;
    wire        vdt_off_w;
    wire [3:0]  pair_w;
    wire [1:0]  low_w;
    wire        vdt_bad_w;
    wire [9:0]  ar_idx;

    wdt_option_decode u_wdt (
        .wdt_byte          (img_q[0]),
        .overflow_exponent (exp_w),
        .interval_point    (ipoint_w),
        .window_prohibited (win_bad_w)
    );

    vdt_option_decode u_vdt (
        .vdt_byte       (img_q[1]),
        .detector_off   (vdt_off_w),
        .pair_index     (pair_w),
        .low_index      (low_w),
        .vdt_prohibited (vdt_bad_w)
    );

    // ****************************************
    // Flash fetch sequencer
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q       <= S_START;
            byte_cnt_q    <= 2'h0;
            swap_q        <= 1'b0;
            flash_rd_req  <= 1'b0;
            flash_rd_addr <= `OB_FLASH_BASE;
            img_q[0]      <= `OB_RST_BYTE;
            img_q[1]      <= `OB_RST_BYTE;
            img_q[2]      <= `OB_RST_BYTE;
            img_q[3]      <= `OB_RST_BYTE;
            loaded_q      <= 1'b0;
        end else begin
            case (state_q)
                S_START: begin
                    // Boot swap picks the mirror range
                    swap_q        <= boot_swap;
                    flash_rd_addr <= boot_swap ? `OB_FLASH_MIRROR : `OB_FLASH_BASE;
                    flash_rd_req  <= 1'b1;
                    byte_cnt_q    <= 2'h0;
                    state_q       <= S_FETCH;
                end
                S_FETCH: begin
                    if (flash_rd_valid) begin
                        img_q[byte_cnt_q] <= flash_rd_data;
                        byte_cnt_q        <= byte_cnt_q + 2'h1;
                        flash_rd_addr     <= flash_rd_addr + 17'h00001;
                        if (byte_cnt_q == 2'h3) begin
                            flash_rd_req <= 1'b0;
                            state_q      <= S_APPLY;
                        end
                    end
                end
                S_APPLY: begin
                    loaded_q <= 1'b1;
                    state_q  <= S_DONE;
                end
                default: begin
                    if (reload_q) begin
                        state_q <= S_START;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            reset_hold_n         <= 1'b0;
            wdt_q                <= `OB_RST_BYTE;
            vdt_q                <= `OB_RST_BYTE;
            watchdog_run_enable  <= 1'b0;
            watchdog_count_gate  <= 1'b0;
            standby_count_enable <= 1'b0;
            overflow_period_sel  <= 3'h0;
            overflow_exponent    <= 5'h00;
            interval_irq_select  <= 1'b0;
            interval_point       <= 17'h00000;
            refresh_span_hi      <= 1'b0;
            refresh_span_lo      <= 1'b0;
            detector_mode        <= 2'h0;
            voltage_class        <= 3'h0;
            level_select         <= 2'h0;
            detector_off         <= 1'b0;
            threshold_pair_index <= 4'h0;
            low_threshold_index  <= 2'h0;
            fast_osc_flash_byte  <= `OB_RST_BYTE;
            debug_option_byte    <= `OB_RST_BYTE;
            config_error         <= 1'b0;
        end else begin
            if (state_q == S_APPLY) begin
                // Latch every field in one edge
                wdt_q                <= img_q[0];
                vdt_q                <= img_q[1];
                watchdog_run_enable  <= img_q[0][`OB_WDT_RUN];
                standby_count_enable <= img_q[0][`OB_WDT_STBY];
                overflow_period_sel  <= img_q[0][`OB_WDT_PER_HI:`OB_WDT_PER_LO];
                overflow_exponent    <= exp_w;
                interval_irq_select  <= img_q[0][`OB_WDT_IRQ];
                // No interval point when the select bit is clear
                interval_point       <= img_q[0][`OB_WDT_IRQ] ? ipoint_w : 17'h00000;
                refresh_span_hi      <= img_q[0][`OB_WDT_WIN_HI];
                refresh_span_lo      <= img_q[0][`OB_WDT_WIN_LO];
                detector_mode        <= img_q[1][`OB_VDT_MODE_HI:`OB_VDT_MODE_LO];
                voltage_class        <= img_q[1][`OB_VDT_VPOC_HI:`OB_VDT_VPOC_LO];
                level_select         <= img_q[1][`OB_VDT_LVIS_HI:`OB_VDT_LVIS_LO];
                detector_off         <= vdt_off_w;
                threshold_pair_index <= pair_w;
                low_threshold_index  <= low_w;
                fast_osc_flash_byte  <= img_q[2];
                debug_option_byte    <= img_q[3];
                config_error         <= win_bad_w | vdt_bad_w;
            end
            // Hold processor and watchdog until fields are latched
            reset_hold_n <= loaded_q;
            // Count only after release, halted in low power unless enabled
            watchdog_count_gate <= reset_hold_n & watchdog_run_enable
                                   & (standby_count_enable | ~low_power_state);
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `OB_RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_idx_q      <= 10'h000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            reload_q      <= 1'b0;
        end else begin
            reload_q <= 1'b0;
            if (!aw_have_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_have_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_idx_q      <= word_index(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_idx_q == `OB_IDX_CTRL) begin
                    s_axi_bresp <= `OB_RESP_OKAY;
                    reload_q    <= w_strb_q[0] & w_data_q[`OB_CTRL_RELOAD];
                end else if (aw_idx_q >= `OB_IDX_WDT && aw_idx_q <= `OB_IDX_STATUS) begin
                    // Option bytes are read only
                    s_axi_bresp <= `OB_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `OB_RESP_DECERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    assign ar_idx = word_index(s_axi_araddr);

    always @* begin
        rd_word = 32'h00000000;
        rd_resp = `OB_RESP_OKAY;
        if (ar_idx == `OB_IDX_WDT) begin
            rd_word[7:0] = wdt_q;
        end else if (ar_idx == `OB_IDX_VDT) begin
            rd_word[7:0] = vdt_q;
        end else if (ar_idx == `OB_IDX_OSC) begin
            rd_word[7:0] = fast_osc_flash_byte;
        end else if (ar_idx == `OB_IDX_DBG) begin
            rd_word[7:0] = debug_option_byte;
        end else if (ar_idx == `OB_IDX_STATUS) begin
            rd_word[3:0] = {swap_q, config_error, reset_hold_n, loaded_q};
        end else if (ar_idx == `OB_IDX_CTRL) begin
            rd_word = 32'h00000000;
        end else begin
            rd_resp = `OB_RESP_DECERR;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `OB_RESP_OKAY;
        end else begin
            if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_resp;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/option_byte_sva.sv ====
// Concurrent checks on the option byte loader ports
module option_byte_sva (
    input logic        aclk,
    input logic        aresetn,
    input logic        flash_rd_req,
    input logic [16:0] flash_rd_addr,
    input logic        flash_rd_valid,
    input logic        low_power_state,
    input logic        reset_hold_n,
    input logic        watchdog_count_gate,
    input logic        standby_count_enable,
    input logic [2:0]  overflow_period_sel,
    input logic [4:0]  overflow_exponent,
    input logic        interval_irq_select,
    input logic [16:0] interval_point,
    input logic        refresh_span_hi,
    input logic        refresh_span_lo,
    input logic        config_error
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Fetch and decode
    // ****************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       take;
    logic       fourth;
    logic [4:0] ex_tab [8] = '{5'h6, 5'h7, 5'h8, 5'h9, 5'hb, 5'hd, 5'he, 5'h10};
    assign take = flash_rd_req && flash_rd_valid;
    assign fourth = flash_rd_addr[1:0] == 2'h3;
    property p_start; $rose(aresetn) |-> ##[1:2] flash_rd_req; endproperty
    a_start: assert property (p_start) else $error("no fetch after reset");
    property p_step; take && !fourth |=> flash_rd_req && flash_rd_addr == $past(flash_rd_addr) + 17'h1; endproperty
    a_step: assert property (p_step) else $error("fetch address step wrong");
    property p_drop; take && fourth |=> !flash_rd_req ##[0:3] reset_hold_n; endproperty
    a_drop: assert property (p_drop) else $error("fetch end wrong");
    property p_no_sw; $changed(overflow_period_sel) |-> $past(flash_rd_req, 2) || $past(flash_rd_req, 3); endproperty
    a_no_sw: assert property (p_no_sw) else $error("config changed without fetch");
    property p_exp; reset_hold_n |-> overflow_exponent == ex_tab[overflow_period_sel]; endproperty
    a_exp: assert property (p_exp) else $error("overflow exponent wrong");
    property p_ipt; reset_hold_n && !interval_irq_select |-> interval_point == 17'h0; endproperty
    a_ipt: assert property (p_ipt) else $error("interval point without select");
    property p_stby; low_power_state && !standby_count_enable |=> !watchdog_count_gate; endproperty
    a_stby: assert property (p_stby) else $error("counting in low power");
    property p_win; reset_hold_n && !refresh_span_hi && !refresh_span_lo |-> config_error; endproperty
    a_win: assert property (p_win) else $error("window 00 not flagged");
    c_mirror: cover property (take && flash_rd_addr[12]);
    c_err: cover property (reset_hold_n && config_error);
    c_gate: cover property (watchdog_count_gate && low_power_state);
endmodule

// ==== bench/option_flash_model.sv ====
// Flash array model holding the option byte image
module option_flash_model (
    input  logic        aclk,
    input  logic        flash_rd_req,
    input  logic [16:0] flash_rd_addr,
    input  logic [1:0]  gap,
    output logic [7:0]  flash_rd_data,
    output logic        flash_rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] base_img [4]; // Programmed before use
    logic [7:0] mirr_img [4]; // Swap range copy
    logic [7:0] cur;
    logic [1:0] cnt;
    assign cur = flash_rd_addr[12] ? mirr_img[flash_rd_addr[1:0]] : base_img[flash_rd_addr[1:0]];
    initial begin
        flash_rd_valid = 1'b0;
        flash_rd_data = 8'h00;
        cnt = 2'h0;
    end
    // ****************
    // One pulse per byte
    // ****************
    always @(posedge aclk) begin
        flash_rd_data <= ~flash_rd_data;
        flash_rd_valid <= 1'b0;
        cnt <= 2'h0;
        if (flash_rd_req && !flash_rd_valid) begin
            cnt <= cnt + 2'h1;
            if (cnt == gap) begin
                flash_rd_valid <= 1'b1;
                flash_rd_data <= cur;
            end
        end
    end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the option byte loader
`include "option_byte_consts.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, boot_swap, low_power_state, flash_rd_req, flash_rd_valid, reset_hold_n;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, watchdog_run_enable;
    logic        watchdog_count_gate, standby_count_enable, interval_irq_select, refresh_span_hi;
    logic        refresh_span_lo, detector_off, config_error;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [3:0]  s_axi_wstrb, threshold_pair_index;
    logic [1:0]  s_axi_bresp, s_axi_rresp, detector_mode, level_select, low_threshold_index, gap, rsp;
    logic [16:0] flash_rd_addr, interval_point;
    logic [7:0]  flash_rd_data, fast_osc_flash_byte, debug_option_byte;
    logic [2:0]  overflow_period_sel, voltage_class;
    logic [4:0]  overflow_exponent;
    logic [7:0]  img [4];
    logic [4:0]  rst_tab [$] = '{5'h03, 5'h02, 5'h07, 5'h06, 5'h05, 5'h0b, 5'h0a, 5'h09, 5'h0f, 5'h0e, 5'h0d, 5'h04,
                                 5'h08, 5'h0c};
    int          exps [8] = '{6, 7, 8, 9, 11, 13, 14, 16};
    int          bad_count, cmp_count, seed;
    option_byte_config_decoder i_dut (.*);
    option_flash_model i_flash (.*);
    // ****************
    // Bus and model tasks
    // ****************
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] q);
        logic ad, wdn;
        ad = 1'b0;
        wdn = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wdn)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wready && !wdn) begin wdn = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] q);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        q = s_axi_rresp;
    endtask
    task automatic load(input logic b);
        // Unselected range holds the inverse to expose a wrong fetch
        for (int j = 0; j < 4; j++) begin
            i_flash.base_img[j] = b ? ~img[j] : img[j];
            i_flash.mirr_img[j] = b ? img[j] : ~img[j];
        end
    endtask
    task automatic wait_fetch();
        int n;
        n = 0;
        while (!flash_rd_req && n < 50) begin @(posedge aclk); n++; end
        while (flash_rd_req && n < 300) begin @(posedge aclk); n++; end
        repeat (4) @(posedge aclk);
    endtask
    task automatic check_all(input logic b);
        logic o, bd, pk, e_err;
        logic [3:0] p;
        logic [1:0] l;
        logic [7:0] w;
        int k, e;
        e = exps[img[0][3:1]];
        o = img[1][0] & img[1][7];
        l = (img[1][1:0] == 2'h2) ? img[1][6:5] : 2'h0;
        bd = !o;
        k = -1;
        p = 4'h0;
        for (int j = 0; j < 14; j++) if (rst_tab[j] == {img[1][7:5], img[1][3:2]}) k = j;
        pk = img[1][0] && !o && k >= 0;
        if (pk) begin p = 4'(k); bd = 1'b0; end
        if (img[1][1:0] == 2'h2) begin
            bd = img[1][7] || img[1][3:2] == 2'h3;
            p = 4'(img[1][6:5] * 3 + 2 - img[1][3:2]);
            pk = !bd;
        end
        e_err = bd | (img[0][6:5] == 2'h0);
        w = {interval_irq_select, refresh_span_hi, refresh_span_lo, watchdog_run_enable, overflow_period_sel,
             standby_count_enable};
        `CHK("wdt", img[0], w)
        `CHK("exp", 5'(e), overflow_exponent)
        `CHK("ipt", img[0][7] ? 17'(3 << (e - 2)) : 17'h0, interval_point)
        `CHK("gate", img[0][4] & (img[0][0] | ~low_power_state), watchdog_count_gate)
        `CHK("vdt", {img[1][7:5], img[1][3:0]}, {voltage_class, level_select, detector_mode})
        `CHK("off", o, detector_off)
        if (pk) `CHK("pair", p, threshold_pair_index)
        `CHK("low", l, low_threshold_index)
        `CHK("err", e_err, config_error)
        `CHK("osc", img[2], fast_osc_flash_byte)
        `CHK("dbg", img[3], debug_option_byte)
        `CHK("hold", 1'b1, reset_hold_n)
        for (int j = 0; j < 4; j++) begin
            axi_read(12'(12'h300 + 4 * j), r, rsp);
            `CHK("reg", {24'h0, img[j]}, r)
        end
        axi_read(12'h310, r, rsp);
        `CHK("stat", {28'h0, b, e_err, 2'h3}, r)
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************
    // Clock, watchdog, sequence
    // ****************
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        repeat (8000) @(posedge aclk);
        bad_count++;
        final_report();
    end
    initial begin
        {aresetn, boot_swap, low_power_state, gap, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        bad_count = 0;
        cmp_count = 0;
        seed = 32'h6e8d;
        img = '{8'h6e, 8'hff, 8'he8, 8'h85};
        load(1'b0);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("hold0", 1'b0, reset_hold_n)
        wait_fetch();
        axi_write(12'h300, 32'h5a, 4'hf, rsp);
        `CHK("ro", `OB_RESP_SLVERR, rsp)
        axi_read(12'h400, r, rsp);
        `CHK("unmap", {`OB_RESP_DECERR, 32'h0}, {rsp, r})
        check_all(1'b0);
        for (int i = 0; i < 28; i++) begin
            r = $random(seed);
            img[0] = {r[7], (i == 26) ? 2'h0 : 2'(i % 3 + 1), r[4], 3'(i % 8), r[0]};
            img[1] = i < 14 ? {rst_tab[i][4:2], 1'b1, rst_tab[i][1:0], 2'h3} :
                     i < 26 ? {1'b0, 2'((i - 14) / 3), 1'b1, 2'((i - 14) % 3), 2'h2} : (i == 26 ? 8'h7d : 8'h10);
            img[2] = r[15:8];
            img[3] = r[23:16];
            load(i[0]);
            boot_swap <= i[0];
            low_power_state <= r[24];
            gap <= r[26:25];
            @(posedge aclk);
            if (i == 14) begin
                aresetn <= 1'b0;
                repeat (2) @(posedge aclk);
                aresetn <= 1'b1;
            end else begin
                axi_write(12'h314, 32'h1, 4'h1, rsp);
                `CHK("ctl", `OB_RESP_OKAY, rsp)
            end
            wait_fetch();
            check_all(i[0]);
        end
        final_report();
    end
endmodule
bind option_byte_config_decoder option_byte_sva i_sva (.*);
